// File: hw/gspc_pkg.sv
// package: register map, field layout, reset values and timing for the gauge status pin control
package gspc_pkg;

  // apb geometry
  localparam int          ADDR_W = 8;                 // byte address width seen by the block
  localparam int          DATA_W = 32;                // apb data width

  // register byte offsets
  localparam logic [7:0]  OFS_PIN_CFG    = 8'h00;     // pin_pullup_and_spike_config
  localparam logic [7:0]  OFS_PULSE_CFG  = 8'h04;     // interrupt_pulse_source_config
  localparam logic [7:0]  OFS_CTRL       = 8'h08;     // pin function, polarities, insertion detect
  localparam logic [7:0]  OFS_CMD        = 8'h0c;     // host insert/remove strobes, write only
  localparam logic [7:0]  OFS_TEMP_LIM   = 8'h10;     // charge inhibit limits and hysteresis
  localparam logic [7:0]  OFS_STATUS     = 8'h14;     // live state, read only

  // pin_pullup_and_spike_config fields
  localparam int          PC_GOOD_SPU    = 7;
  localparam int          PC_GOOD_WPU    = 6;
  localparam int          PC_LOW_SPU     = 5;
  localparam int          PC_LOW_WPU     = 4;
  localparam int          PC_SLEEP_COMP  = 2;
  localparam int          PC_SPIKE_LO    = 0;         // spike option occupies bits 1:0
  localparam logic [7:0]  PC_MASK        = 8'hf7;     // bit3 reserved
  localparam logic [7:0]  PC_RESET       = 8'h24;

  // interrupt_pulse_source_config fields
  localparam int          PS_STATE       = 5;
  localparam int          PS_OCV         = 4;
  localparam int          PS_FLASH       = 3;
  localparam int          PS_OVER_TEMP   = 2;
  localparam int          PS_FAST_CAP    = 0;
  localparam logic [7:0]  PS_MASK        = 8'h3d;     // bits 7, 6, 1 reserved
  localparam logic [7:0]  PS_RESET       = 8'h3c;

  // control register fields
  localparam int          CT_SEL_LO      = 0;         // pin_function_sel_lo
  localparam int          CT_SEL_HI      = 1;         // pin_function_sel_hi
  localparam int          CT_LOW_POL     = 2;
  localparam int          CT_GOOD_POL    = 3;
  localparam int          CT_DETECT_EN   = 4;
  localparam logic [4:0]  CT_RESET       = 5'h15;     // code 1, low pol set, good pol clear, detect on

  // command register strobes
  localparam int          CM_INSERT      = 0;
  localparam int          CM_REMOVE      = 1;

  // temperature limit register layout
  localparam int          TL_LOW_LO      = 0;
  localparam int          TL_HIGH_LO     = 8;
  localparam int          TL_HYS_LO      = 16;
  localparam logic [7:0]  TL_LOW_RESET   = 8'h00;
  localparam logic [7:0]  TL_HIGH_RESET  = 8'h2d;
  localparam logic [7:0]  TL_HYS_RESET   = 8'h05;

  // thermistor adc code treated as near 2.5 v (disconnected)
  localparam logic [11:0] ADC_OPEN_CODE  = 12'hf00;

  // timing
  localparam longint      CLK_HZ         = 40000000;
  localparam longint      POLL_PERIOD_MS = 1000;      // presence poll period
  localparam longint      POLL_CYCLES    = (POLL_PERIOD_MS * CLK_HZ) / 1000;

  // battery activity reported by the gauging core
  typedef enum logic [1:0] {
    GSPC_DISCHARGE,
    GSPC_CHARGE,
    GSPC_RELAX
  } gspc_activity_type;

  // spike voltage determination method
  typedef enum logic [1:0] {
    GSPC_SPIKE_AVERAGED,
    GSPC_SPIKE_INSTANT,
    GSPC_SPIKE_STORED_MIN,
    GSPC_SPIKE_UNUSED
  } gspc_spike_type;

  // decoded pin function code
  typedef enum logic [1:0] {
    GSPC_PFC_GAUGE_ONLY,
    GSPC_PFC_CHARGE_CTRL,
    GSPC_PFC_SHARED,
    GSPC_PFC_INVALID
  } gspc_pfc_type;

endpackage

// File: hw/gspc_presence.sv
// battery presence tracker: one second poll of the detect pin or host commands
`timescale 1ns/1ps
`default_nettype none
module gspc_presence #(
  parameter int unsigned POLL_CYCLES = 40000000
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // configuration
  input  wire logic        detect_en,
  // pin and analog sense
  input  wire logic        detect_pin_i,
  input  wire logic [11:0] therm_code,
  // host commands, one cycle strobes
  input  wire logic        insert_cmd,
  input  wire logic        remove_cmd,
  // results
  output logic             battery_detected,
  output logic             poll_tick,
  output logic             inserted
);

  // all state of the tracker
  typedef struct packed {
    logic [31:0] count;      // cycles into the current poll period
    logic        detected;   // battery present
    logic        tick;       // poll instant
    logic        ins;        // presence went from absent to present
  } gspc_pres_state_type;

  gspc_pres_state_type s_q;   // registered state
  gspc_pres_state_type s_d;   // next state

  localparam logic [31:0] LAST = 32'(POLL_CYCLES - 1);   // final count of a period

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    s_d.ins  = 1'b0;
    // free running period counter; runs whenever the part is powered
    if (s_q.count == LAST) begin
      s_d.count = 32'h0000_0000;
      s_d.tick  = 1'b1;
    end else begin
      s_d.count = s_q.count + 32'h0000_0001;
    end
    if (detect_en) begin
      // pin held high-z outside; low means a pack pulls it down
      if (s_d.tick) begin
        s_d.detected = !detect_pin_i
                       && (therm_code < gspc_pkg::ADC_OPEN_CODE);
      end
    end else begin
      // host keeps presence; insert wins if both strobes coincide
      if (insert_cmd) begin
        s_d.detected = 1'b1;
      end else if (remove_cmd) begin
        s_d.detected = 1'b0;
      end
    end
    s_d.ins = s_d.detected && !s_q.detected;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign battery_detected = s_q.detected;
  assign poll_tick        = s_q.tick;
  assign inserted         = s_q.ins;

endmodule
`default_nettype wire

// File: hw/gspc_top.sv
// top: configuration registers, status pins and temperature arrangement of the gauge
//
// Notes on behaviour
// - separate strong/weak pull-ups; low strong default on
// - sleep-wake charge compensation enable, default set
// - spike option selects averaged, instant, stored minimum
// - state-change pulse enable, default set
// - open-circuit measurement pulse enable, default set
// - flash-write pulse enable, default set
// - over-temperature pulse enable, default set
// - fast capacity update enable, default clear
// - code 0: no charge-time temperature, no charger control
// - code 1: charge-time monitoring, good pin inhibits charger
// - code 2: thermistor belongs to charger while charging
// - codes 0, 2 sample temperature only on query
// - pin function code from two bits, default 1
// - low pin follows low-charge flag, invertible polarity
// - good pin negated after insertion until voltage read
// - inhibit released only inside hysteresis band
// - detect pin high-z, low level means present
// - poll detect pin once each second
// - thermistor near 2.5 v means disconnected
// - detection off: host insert/remove set presence
// - patterns 0/0, 0/1, 1/0 give codes 0, 1, 2
// - low polarity set means active-high, default set
// - good polarity clear means active-low, default clear
`timescale 1ns/1ps
`default_nettype none
module gspc_top #(
  parameter int unsigned POLL_CYCLES = 32'(gspc_pkg::POLL_CYCLES)
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // gauging core status
  input  wire logic        low_charge_flag,
  input  wire logic [1:0]  activity,
  input  wire logic        ocv_complete,
  input  wire logic        ocv_cmd_event,
  input  wire logic        flash_write_event,
  input  wire logic        over_temp_event,
  input  wire logic        wake_event,
  input  wire logic        temp_query,
  input  wire logic        temp_valid,
  input  wire logic [7:0]  temperature,
  input  wire logic [11:0] therm_code,
  // gauging core controls
  output logic             pulse_request,
  output logic             wake_comp_request,
  output logic [1:0]       spike_method,
  output logic             fast_capacity_update_en,
  output logic             temp_sample_request,
  output logic             temp_available,
  output logic             battery_detected,
  // status pins
  output logic             battery_low_pin,
  output logic             low_pin_strong_pullup_en,
  output logic             low_pin_weak_pullup_en,
  output logic             battery_good_pin,
  output logic             good_pin_strong_pullup_en,
  output logic             good_pin_weak_pullup_en,
  // thermistor detect pin
  input  wire logic        thermistor_detect_pin_i,
  output logic             thermistor_detect_pin_o,
  output logic             thermistor_detect_pin_oe
);

  //////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // two configuration bits to pin function code
  function automatic gspc_pkg::gspc_pfc_type pfc_of(input logic [4:0] ctrl);
    logic [1:0] pat;
    pat = {ctrl[gspc_pkg::CT_SEL_HI], ctrl[gspc_pkg::CT_SEL_LO]};
    case (pat)
      2'h0:    pfc_of = gspc_pkg::GSPC_PFC_GAUGE_ONLY;
      2'h1:    pfc_of = gspc_pkg::GSPC_PFC_CHARGE_CTRL;
      2'h2:    pfc_of = gspc_pkg::GSPC_PFC_SHARED;
      default: pfc_of = gspc_pkg::GSPC_PFC_INVALID;
    endcase
  endfunction

  // spike option field to method
  function automatic gspc_pkg::gspc_spike_type spike_of(input logic [7:0] cfg);
    case (cfg[gspc_pkg::PC_SPIKE_LO +: 2])
      2'h0:    spike_of = gspc_pkg::GSPC_SPIKE_AVERAGED;
      2'h1:    spike_of = gspc_pkg::GSPC_SPIKE_INSTANT;
      2'h2:    spike_of = gspc_pkg::GSPC_SPIKE_STORED_MIN;
      default: spike_of = gspc_pkg::GSPC_SPIKE_UNUSED;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state

  // every flop of the block except those inside the presence tracker
  typedef struct packed {
    logic [7:0]  pin_cfg;       // pin_pullup_and_spike_config
    logic [7:0]  pulse_cfg;     // interrupt_pulse_source_config
    logic [4:0]  ctrl;          // pin function, polarities, detect enable
    logic [7:0]  lim_low;       // charge inhibit low limit
    logic [7:0]  lim_high;      // charge inhibit high limit
    logic [7:0]  hys;           // release hysteresis
    logic [31:0] rdata;         // apb read data
    logic        ready;         // apb ready
    logic        err;           // apb error
    logic        ins_cmd;       // host insert strobe
    logic        rem_cmd;       // host remove strobe
    logic        ocv_done;      // voltage reading taken since insertion
    logic        inhibit;       // charge inhibited by temperature
    logic [1:0]  prev_act;      // activity one cycle ago
    logic        pulse;         // interrupt pulse request
    logic        wake_comp;     // compensate charge missed in sleep
    logic [1:0]  spike;         // decoded spike method
    logic        sample;        // temperature sample request
    logic        temp_avail;    // temperature data usable
    logic        low_pin;       // battery low pin level
    logic        good_pin;      // battery good pin level
    logic        therm_oe;      // thermistor bias drive
  } gspc_state_type;

  gspc_state_type s_q;   // registered state
  gspc_state_type s_d;   // next state

  // presence tracker results
  logic present;    // battery present
  logic tick;       // one second poll instant
  logic inserted;   // presence just appeared

  //////////////////////////////////////////////////////////////////////////////
  // presence tracking

  gspc_presence #(
    .POLL_CYCLES (POLL_CYCLES)
  ) u_presence (
    .pclk             (pclk),
    .presetn          (presetn),
    .detect_en        (s_q.ctrl[gspc_pkg::CT_DETECT_EN]),
    .detect_pin_i     (thermistor_detect_pin_i),
    .therm_code       (therm_code),
    .insert_cmd       (s_q.ins_cmd),
    .remove_cmd       (s_q.rem_cmd),
    .battery_detected (present),
    .poll_tick        (tick),
    .inserted         (inserted)
  );

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic                  setup;      // first access cycle, before ready is set
    logic                  commit;     // access phase completes this edge
    logic [7:0]            ofs;        // word aligned offset
    logic                  mapped;     // offset hits a register
    gspc_pkg::gspc_pfc_type pin_function_code;       // current pin function code
    logic                  charging;   // battery on charge
    logic [8:0]            t9;         // temperature widened
    logic                  out_range;  // outside inhibit limits
    logic                  in_band;    // inside release band
    logic                  good_act;   // good pin logical state
    setup     = 1'b0;
    commit    = 1'b0;
    ofs       = 8'h00;
    mapped    = 1'b0;
    pin_function_code       = pfc_of(s_q.ctrl);
    charging  = (activity == gspc_pkg::GSPC_CHARGE);
    t9        = {1'b0, temperature};
    out_range = 1'b0;
    in_band   = 1'b0;
    good_act  = 1'b0;
    s_d       = s_q;
    s_d.ins_cmd = 1'b0;
    s_d.rem_cmd = 1'b0;
    s_d.pulse   = 1'b0;
    s_d.sample  = 1'b0;
    s_d.wake_comp = 1'b0;

    // apb: one wait state, answer on the second access cycle
    setup  = psel && penable && !s_q.ready;
    commit = psel && penable && s_q.ready;
    ofs    = {paddr[7:2], 2'h0};
    case (ofs)
      gspc_pkg::OFS_PIN_CFG,
      gspc_pkg::OFS_PULSE_CFG,
      gspc_pkg::OFS_CTRL,
      gspc_pkg::OFS_CMD,
      gspc_pkg::OFS_TEMP_LIM,
      gspc_pkg::OFS_STATUS: mapped = 1'b1;
      default:              mapped = 1'b0;
    endcase
    s_d.ready = setup;
    s_d.err   = setup && !mapped;
    if (setup && !pwrite) begin
      // read data latched one cycle ahead so prdata comes from a flop
      case (ofs)
        gspc_pkg::OFS_PIN_CFG:   s_d.rdata = {24'h000000, s_q.pin_cfg};
        gspc_pkg::OFS_PULSE_CFG: s_d.rdata = {24'h000000, s_q.pulse_cfg};
        gspc_pkg::OFS_CTRL:      s_d.rdata = {27'h0000000, s_q.ctrl};
        gspc_pkg::OFS_TEMP_LIM:  s_d.rdata = {8'h00, s_q.hys, s_q.lim_high, s_q.lim_low};
        gspc_pkg::OFS_STATUS:    s_d.rdata = {22'h000000, s_q.spike, pin_function_code, s_q.temp_avail,
                                              s_q.good_pin, s_q.low_pin, s_q.inhibit,
                                              s_q.ocv_done, present};
        default:                 s_d.rdata = 32'h0000_0000;   // command reg and holes
      endcase
    end else if (commit) begin
      s_d.rdata = 32'h0000_0000;
    end
    if (commit && pwrite) begin
      case (ofs)
        // reserved bits are never stored, so they read zero
        gspc_pkg::OFS_PIN_CFG:   s_d.pin_cfg   = pwdata[7:0] & gspc_pkg::PC_MASK;
        gspc_pkg::OFS_PULSE_CFG: s_d.pulse_cfg = pwdata[7:0] & gspc_pkg::PS_MASK;
        gspc_pkg::OFS_CTRL:      s_d.ctrl      = pwdata[4:0];
        gspc_pkg::OFS_CMD: begin
          s_d.ins_cmd = pwdata[gspc_pkg::CM_INSERT];
          s_d.rem_cmd = pwdata[gspc_pkg::CM_REMOVE];
        end
        gspc_pkg::OFS_TEMP_LIM: begin
          s_d.lim_low  = pwdata[gspc_pkg::TL_LOW_LO  +: 8];
          s_d.lim_high = pwdata[gspc_pkg::TL_HIGH_LO +: 8];
          s_d.hys      = pwdata[gspc_pkg::TL_HYS_LO  +: 8];
        end
        default: begin
          // status is read only; holes ignore writes
        end
      endcase
    end

    // configuration options handed to the gauging core
    s_d.spike     = spike_of(s_q.pin_cfg);
    s_d.wake_comp = wake_event && s_q.pin_cfg[gspc_pkg::PC_SLEEP_COMP];

    // interrupt pulse sources, each gated by its enable
    s_d.prev_act = activity;
    if (s_q.pulse_cfg[gspc_pkg::PS_STATE] && (activity != s_q.prev_act)) begin
      s_d.pulse = 1'b1;
    end
    if (s_q.pulse_cfg[gspc_pkg::PS_OCV] && ocv_cmd_event) begin
      s_d.pulse = 1'b1;
    end
    if (s_q.pulse_cfg[gspc_pkg::PS_FLASH] && flash_write_event) begin
      s_d.pulse = 1'b1;
    end
    if (s_q.pulse_cfg[gspc_pkg::PS_OVER_TEMP] && over_temp_event) begin
      s_d.pulse = 1'b1;
    end

    // temperature arrangement by pin function code
    case (pin_function_code)
      gspc_pkg::GSPC_PFC_CHARGE_CTRL: begin
        // periodic sampling, also while charging
        s_d.sample     = tick || temp_query;
        s_d.temp_avail = 1'b1;
      end
      gspc_pkg::GSPC_PFC_SHARED: begin
        // charger owns the thermistor while charging
        s_d.sample     = temp_query && !charging;
        s_d.temp_avail = !charging;
      end
      default: begin
        // gauge only: sample on query, never while charging
        s_d.sample     = temp_query && !charging;
        s_d.temp_avail = !charging;
      end
    endcase

    // charge inhibit with hysteresis, only meaningful in code 1
    out_range = (t9 < {1'b0, s_q.lim_low}) || (t9 > {1'b0, s_q.lim_high});
    in_band   = (t9 >= ({1'b0, s_q.lim_low} + {1'b0, s_q.hys}))
                && ({1'b0, t9} + {1'b0, s_q.hys} <= {1'b0, s_q.lim_high});
    if (pin_function_code != gspc_pkg::GSPC_PFC_CHARGE_CTRL) begin
      s_d.inhibit = 1'b0;
    end else if (temp_valid) begin
      if (charging && out_range) begin
        s_d.inhibit = 1'b1;
      end else if (s_q.inhibit && in_band) begin
        s_d.inhibit = 1'b0;
      end
    end

    // voltage reading gate after insertion; completion wins a tie
    if (ocv_complete && present) begin
      s_d.ocv_done = 1'b1;
    end else if (inserted || !present) begin
      s_d.ocv_done = 1'b0;
    end

    // pin levels with polarity
    good_act     = present && s_q.ocv_done && !s_q.inhibit;
    s_d.good_pin = s_q.ctrl[gspc_pkg::CT_GOOD_POL] ? good_act : !good_act;
    s_d.low_pin  = s_q.ctrl[gspc_pkg::CT_LOW_POL] ? low_charge_flag
                                                   : !low_charge_flag;

    // detect pin floats while detection runs; bias only for samples otherwise
    s_d.therm_oe = !s_q.ctrl[gspc_pkg::CT_DETECT_EN] && s_d.sample;
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q           <= '0;
      s_q.pin_cfg   <= gspc_pkg::PC_RESET;
      s_q.pulse_cfg <= gspc_pkg::PS_RESET;
      s_q.ctrl      <= gspc_pkg::CT_RESET;
      s_q.lim_low   <= gspc_pkg::TL_LOW_RESET;
      s_q.lim_high  <= gspc_pkg::TL_HIGH_RESET;
      s_q.hys       <= gspc_pkg::TL_HYS_RESET;
      s_q.good_pin  <= 1'b1;   // negated for active-low default
      s_q.low_pin   <= 1'b0;   // flag clear, active-high default
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops

  // apb
  assign prdata  = s_q.rdata;
  assign pready  = s_q.ready;
  assign pslverr = s_q.err;

  // gauging core
  assign pulse_request           = s_q.pulse;
  assign wake_comp_request       = s_q.wake_comp;
  assign spike_method            = s_q.spike;
  assign fast_capacity_update_en = s_q.pulse_cfg[gspc_pkg::PS_FAST_CAP];
  assign temp_sample_request     = s_q.sample;
  assign temp_available          = s_q.temp_avail;
  assign battery_detected        = present;

  // pins and their pull-ups
  assign battery_low_pin           = s_q.low_pin;
  assign battery_good_pin          = s_q.good_pin;
  assign low_pin_strong_pullup_en  = s_q.pin_cfg[gspc_pkg::PC_LOW_SPU];
  assign low_pin_weak_pullup_en    = s_q.pin_cfg[gspc_pkg::PC_LOW_WPU];
  assign good_pin_strong_pullup_en = s_q.pin_cfg[gspc_pkg::PC_GOOD_SPU];
  assign good_pin_weak_pullup_en   = s_q.pin_cfg[gspc_pkg::PC_GOOD_WPU];
  assign thermistor_detect_pin_o   = s_q.therm_oe;
  assign thermistor_detect_pin_oe  = s_q.therm_oe;

endmodule
`default_nettype wire

// File: testbench/gspc_chk.sv
// checker: port assertions for the gauge status pin control
`timescale 1ns/1ps
`default_nettype none
module gspc_chk (
  // watched ports
  input wire logic       pclk, presetn, psel, penable, pwrite, pready,
  input wire logic [7:0] paddr,
  input wire logic       wake_event, wake_comp_request, fast_capacity_update_en,
  input wire logic [1:0] spike_method,
  input wire logic       temp_sample_request,
  input wire logic       low_charge_flag, battery_low_pin, low_pin_strong_pullup_en,
  input wire logic       thermistor_detect_pin_o, thermistor_detect_pin_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready) else $error("no single wait");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  rst_pull_a: assert property ($rose(presetn) |-> low_pin_strong_pullup_en) else $error("pullup reset");
  wake_comp_a: assert property (wake_comp_request |-> $past(wake_event)) else $error("stray wake");
  spike_wr_a: assert property ($changed(spike_method) |-> $past(pready && pwrite && paddr == 8'h00, 2))
    else $error("spike changed alone");
  fast_cap_a: assert property ($changed(fast_capacity_update_en) |-> $past(pready && pwrite && paddr == 8'h04))
    else $error("fast cap changed alone");
  low_follow_a: assert property ($changed(low_charge_flag) |=> $changed(battery_low_pin))
    else $error("low pin lag");
  detect_hiz_a: assert property (thermistor_detect_pin_oe |-> temp_sample_request) else $error("pin");
  // main scenarios reached
  cover property (pready && pwrite);
  cover property ($rose(battery_low_pin));
  cover property (wake_comp_request);
endmodule
`default_nettype wire

// File: testbench/gspc_pack.sv
// partner: battery pack with thermistor on a pulled-up detect pin
`timescale 1ns/1ps
`default_nettype none
module gspc_pack (
  input  wire logic  present,
  output logic       pin,
  output logic [11:0] code
);
  // pull-up holds the pin high with no pack; the pack pulls it low
  assign pin = !present;
  // open thermistor reads near 2.5 v
  assign code = present ? 12'h400 : 12'hf00;
endmodule
`default_nettype wire

// File: testbench/tb_gspc_top.sv
// testbench: gspc_top driven over apb beside a pack model
`timescale 1ns/1ps
`default_nettype none
module tb_gspc_top;
  logic        pclk, presetn, psel, penable, pwrite, lcf, present, pin, o, oe, rdy, err, pr, det, lo, gd;
  logic        wk, fc, ts, ta;
  logic [3:0]  pu;
  logic [7:0]  paddr, tmp;
  logic [31:0] pwdata, prdata;
  logic [1:0]  act, spk;
  logic [6:0]  ev;
  logic [11:0] code;
  logic [32:0] exq[$];
  int          n_fail, compares, i;
  gspc_pack u_pack (.present(present), .pin(pin), .code(code));
  gspc_top #(.POLL_CYCLES(50)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(rdy), .pslverr(err),
    .low_charge_flag(lcf), .activity(act), .ocv_complete(ev[6]), .ocv_cmd_event(ev[5]),
    .flash_write_event(ev[4]), .over_temp_event(ev[3]), .wake_event(ev[2]), .temp_query(ev[1]),
    .temp_valid(ev[0]), .temperature(tmp), .therm_code(code), .pulse_request(pr), .wake_comp_request(wk),
    .spike_method(spk), .fast_capacity_update_en(fc), .temp_sample_request(ts), .temp_available(ta),
    .battery_detected(det), .battery_low_pin(lo), .low_pin_strong_pullup_en(pu[1]), .low_pin_weak_pullup_en(pu[0]),
    .battery_good_pin(gd), .good_pin_strong_pullup_en(pu[3]), .good_pin_weak_pullup_en(pu[2]),
    .thermistor_detect_pin_i(oe ? o : pin), .thermistor_detect_pin_o(o), .thermistor_detect_pin_oe(oe));
  initial begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [32:0] s, e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one apb transfer, held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (!rdy && ++k < 9);
    if (k >= 9) begin n_fail++; test_done; end
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exq.push_back(e);
    apb(0, a, 0);
  endtask
  // one-cycle event, pulse request looked at in its one cycle
  task automatic pulse(input int b, input logic e);
    ev <= 7'(1 << b);
    @(posedge pclk) ev <= 0;
    @(posedge pclk) chk("pulse", pr, e);
    chk("wake", wk, b == 2);
  endtask
  task automatic wait_det(input logic e);
    int k;
    for (k = 0; k < 80 && det !== e; k++) @(posedge pclk);
    chk("det", det, e);
    if (k == 80) test_done;
  endtask
  // read watcher: oldest note against pslverr and prdata
  always @(posedge pclk) if (rdy && !pwrite) chk("rd", {err, prdata}, exq.pop_front());
  initial begin
    {psel, penable, pwrite, lcf, present, presetn, paddr, pwdata, act, ev} = 0;
    tmp = 8'h19;
    void'($urandom(32'h6ffd));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk("pu", pu, 4'h2);
    rd(8'h00, 33'h24);
    rd(8'h04, 33'h3c);
    rd(8'h08, 33'h15);
    rd(8'h18, 33'h1_0000_0000);
    i = $urandom | 1;
    apb(1, 8'h00, i);
    rd(8'h00, {25'h0, i[7:0] & 8'hf7});
    apb(1, 8'h04, i);
    rd(8'h04, {25'h0, i[7:0] & 8'h3d});
    chk("fast", fc, 1);
    for (i = 0; i < 4; i++) begin
      apb(1, 8'h00, i | 4);
      @(posedge pclk) chk("spike", spk, i[1:0]);
    end
    apb(1, 8'h04, 8'h3c);
    for (i = 3; i < 6; i++) pulse(i, 1);
    pulse(2, 0);
    act <= 1;
    repeat (2) @(posedge pclk);
    chk("state", pr, 1);
    apb(1, 8'h04, 0);
    pulse(3, 0);
    lcf <= 1;
    repeat (2) @(posedge pclk);
    chk("low", lo, 1);
    apb(1, 8'h08, 8'h11);
    @(posedge pclk) chk("lowpol", lo, 0);
    present <= 1;
    wait_det(1);
    chk("gd", gd, 1);
    pulse(6, 0);
    @(posedge pclk) chk("gd", gd, 0);
    present <= 0;
    wait_det(0);
    apb(1, 8'h08, 8'h05);
    apb(1, 8'h0c, 1);
    wait_det(1);
    pulse(6, 0);
    @(posedge pclk) chk("gd", gd, 0);
    tmp <= 8'h40;
    pulse(0, 0);
    @(posedge pclk) chk("gd", gd, 1);
    tmp <= 8'h2a;
    pulse(0, 0);
    @(posedge pclk) chk("gd", gd, 1);
    tmp <= 8'h20;
    pulse(0, 0);
    @(posedge pclk) chk("gd", gd, 0);
    apb(1, 8'h0c, 2);
    wait_det(0);
    apb(1, 8'h08, 8'h06);
    @(posedge pclk) chk("avail", ta, 0);
    apb(1, 8'h08, 8'h04);
    act <= 2;
    pulse(1, 0);
    chk("query", ts, 1);
    chk("avail", ta, 1);
    test_done;
  end
endmodule
bind gspc_top gspc_chk u_chk (.*);
`default_nettype wire
